// [verilog/irxdv_pkg.sv]
/*
  package for the isochronous receive video enhancement block:
  register offsets, field positions, packet constants and carriers.
  assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package irxdv_pkg;
  localparam int NUM_CTX = 4;
  // register aliases in extension space (byte offsets)
  localparam logic [11:0] OFF_ENH_SET = 12'hA80;
  localparam logic [11:0] OFF_ENH_CLEAR = 12'hA84;
  // field positions and mask of implemented bits
  localparam int CTX_STRIDE = 4;
  localparam int STRIP_POS = 0;
  localparam int SYNC_POS = 1;
  localparam logic [31:0] ENH_MASK = 32'h0000_3333;
  localparam logic [31:0] ENH_RESET = 32'h0000_0000;
  // descriptor branch field value that enables frame sync
  localparam logic [1:0] BRANCH_FILL = 2'h1;
  // frame start tag in the third quadlet
  localparam logic [7:0] TAG_BYTE0 = 8'h1F;
  localparam logic [3:0] TAG_NIBBLE1 = 4'h7;
  localparam int HDR_QUADS = 2;
  localparam int TAG_QUAD = 2;
  localparam int FIFO_DEPTH = 8;

  // register access from host
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [11:0] addr;
    logic [31:0] wrData;
  } irxdv_bus_t;

  // one payload quadlet with framing
  typedef struct packed {
    logic [31:0] data;
    logic first;
    logic last;
  } irxdv_quad_t;
endpackage
`default_nettype wire

// [verilog/irxdv_fifo.sv]
/*
  small synchronous fifo with valid/ready handshake on both sides.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module irxdv_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 8
) (
  input wire logic clk,               // system clock
  input wire logic reset,             // sync reset
  input wire logic [WIDTH-1:0] inData,// write data
  input wire logic inValid,           // write request
  output logic inReady,               // not full
  output logic [WIDTH-1:0] outData,   // head data
  output logic outValid,              // not empty
  input wire logic outReady           // consumer takes head
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic doWr;
  logic doRd;

  // handshake terms
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;
  assign inReady = count != (AW+1)'(DEPTH);
  assign outValid = count != '0;
  assign outData = mem[rdPtr];

  // storage
  always_ff @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr] <= inData;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk) begin
    if (reset) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWr) begin
        wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
      end
      if (doRd) begin
        rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
      end
      if (doWr && !doRd) begin
        count <= count + 1'b1;
      end else if (doRd && !doWr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [verilog/irxdv_enh.sv]
/*
  isochronous receive video enhancement register with its payload path:
  set/clear register aliases, per-context header strip and frame sync.
  assumes a simple synchronous register port from the host bus, one
  receive quadlet stream tagged with a context number, and per-context
  header-included flags and descriptor branch fields from the contexts.
*/
// Summary of operation
// [RQ1] software changes bits only while that context is neither active nor running
// [RQ2] one register, set alias at A80h, clear alias at A84h, reads current value
// [RQ3] zeros written through either alias leave the bit unchanged
// [RQ4] unused bits read zero and ignore writes
// [RQ5] bit 0 set: context 0 drops first two payload quadlets
// [RQ6] bit 4 set: context 1 drops first two payload quadlets
// [RQ7] bit 8 set: context 2 drops first two payload quadlets
// [RQ8] bit 12 set: context 3 drops first two payload quadlets
// [RQ9] bit 1: context 0 waits for frame start, branches on a frame start tag that arrives while already synced
// [RQ10] bit 5: context 1 frame sync and frame branch in buffer-fill mode
// [RQ11] bit 9: context 2 frame sync and frame branch in buffer-fill mode
// [RQ12] bit 13: context 3 frame sync and frame branch in buffer-fill mode
// [RQ13] strip and sync act only while the header-included flag is clear
// [RQ14] frame sync acts only while that context's strip bit is set
// [RQ15] frame start is third quadlet beginning 1Fh then low nibble 7h
// [RQ16] register resets to zero, all enhancements off
`timescale 1ns/1ns
`default_nettype none
module irxdv_enh (
  input wire logic clk,                          // 10 MHz host clock
  input wire logic reset,                        // sync reset, active high
  input wire irxdv_pkg::irxdv_bus_t bus,         // register access
  output logic [31:0] rdData,                    // read data
  output logic [15:0] enhBits,                   // register value to contexts
  input wire logic [3:0] headerIncluded,         // header_included_flag per ctx
  input wire logic [7:0] branchField,            // descriptor b field, 2 bits per ctx
  input wire irxdv_pkg::irxdv_quad_t rxQuad,     // received payload quadlet
  input wire logic [1:0] rxCtx,                  // context of rxQuad
  input wire logic rxValid,                      // rxQuad present
  output logic rxReady,                          // path accepts rxQuad
  output irxdv_pkg::irxdv_quad_t outQuad,        // quadlet to store
  output logic [1:0] outCtx,                     // its context
  output logic outValid,                         // outQuad present
  input wire logic outReady,                     // store takes outQuad
  output logic [3:0] frame_branch_pointer,                // take frame_branch_pointer, pulse
  output logic [3:0] frameSynced                 // context is in frame
);
  localparam int QW = $bits(irxdv_pkg::irxdv_quad_t) + 2;
  localparam int FW = $clog2(irxdv_pkg::FIFO_DEPTH) + 1;

  logic [31:0] enh;
  logic [1:0] quadIdx;
  logic [3:0] stripOn;
  logic [3:0] syncOn;
  logic isTag;
  logic dropQuad;
  logic [QW-1:0] fifoIn;
  logic [QW-1:0] fifoOut;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoWr;
  logic fifoRd;
  logic [FW-1:0] fill;
  logic [FW-1:0] next_fill;
  logic stageValid;
  logic [QW-1:0] stage;
  logic take;

  // register: set/clear aliases, only implemented bits
  always_ff @(posedge clk) begin
    if (reset) begin
      enh <= irxdv_pkg::ENH_RESET; // RQ16
    end else if (bus.wrEn) begin
      if (bus.addr == irxdv_pkg::OFF_ENH_SET) begin
        enh <= enh | (bus.wrData & irxdv_pkg::ENH_MASK); // RQ2
      end else if (bus.addr == irxdv_pkg::OFF_ENH_CLEAR) begin
        enh <= enh & ~(bus.wrData & irxdv_pkg::ENH_MASK); // RQ3
      end
    end
  end

  // read port, either alias returns the value
  always_ff @(posedge clk) begin
    if (reset) begin
      rdData <= '0;
    end else if (bus.rdEn) begin
      if (bus.addr == irxdv_pkg::OFF_ENH_SET || bus.addr == irxdv_pkg::OFF_ENH_CLEAR) begin
        rdData <= enh & irxdv_pkg::ENH_MASK; // RQ4
      end else begin
        rdData <= '0;
      end
    end
  end

  // bits to the contexts, register copy from a flop
  always_ff @(posedge clk) begin
    if (reset) begin
      enhBits <= '0;
    end else begin
      enhBits <= enh[15:0];
    end
  end

  // effective per-context enables
  always_comb begin
    for (int c = 0; c < irxdv_pkg::NUM_CTX; c++) begin
      stripOn[c] = enh[c*irxdv_pkg::CTX_STRIDE + irxdv_pkg::STRIP_POS]
        && !headerIncluded[c]; // RQ5 RQ6 RQ7 RQ8 RQ13
      syncOn[c] = stripOn[c] && enh[c*irxdv_pkg::CTX_STRIDE + irxdv_pkg::SYNC_POS]
        && branchField[c*2 +: 2] == irxdv_pkg::BRANCH_FILL; // RQ9 RQ10 RQ11 RQ12 RQ14
    end
  end

  // frame start tag in the third quadlet
  assign isTag = quadIdx == 2'(irxdv_pkg::TAG_QUAD)
    && rxQuad.data[31:24] == irxdv_pkg::TAG_BYTE0
    && rxQuad.data[19:16] == irxdv_pkg::TAG_NIBBLE1; // RQ15

  assign take = rxValid && rxReady;

  // drop header quadlets, and all data until frame start while syncing
  assign dropQuad = (stripOn[rxCtx] && quadIdx < 2'(irxdv_pkg::HDR_QUADS))
    || (syncOn[rxCtx] && !frameSynced[rxCtx] && !isTag
        && quadIdx >= 2'(irxdv_pkg::TAG_QUAD)); // RQ5 RQ6 RQ7 RQ8

  // fifo handshake terms, mirrored here so ready can come from a flop
  assign fifoWr = rxValid && rxReady && fifoInReady && !dropQuad;
  assign fifoRd = fifoOutValid && (!stageValid || outReady);

  // fill level the fifo will hold after this edge
  always_comb begin
    next_fill = fill;
    if (fifoWr && !fifoRd) begin
      next_fill = fill + 1'b1;
    end else if (fifoRd && !fifoWr) begin
      next_fill = fill - 1'b1;
    end
  end

  // registered ready: room left in the fifo after this edge
  always_ff @(posedge clk) begin
    if (reset) begin
      fill <= '0;
      rxReady <= 1'b0;
    end else begin
      fill <= next_fill;
      rxReady <= next_fill != FW'(irxdv_pkg::FIFO_DEPTH);
    end
  end

  // quadlet position within packet
  always_ff @(posedge clk) begin
    if (reset) begin
      quadIdx <= '0;
    end else if (take) begin
      if (rxQuad.last) begin
        quadIdx <= '0;
      end else if (quadIdx != 2'h3) begin
        quadIdx <= quadIdx + 2'h1;
      end
    end
  end

  // frame sync state, and branch on a frame start tag that arrives while already synced
  always_ff @(posedge clk) begin
    if (reset) begin
      frameSynced <= '0;
      frame_branch_pointer <= '0;
    end else begin
      frame_branch_pointer <= '0;
      for (int c = 0; c < irxdv_pkg::NUM_CTX; c++) begin
        if (!syncOn[c]) begin
          frameSynced[c] <= 1'b0;
        end else if (take && rxCtx == 2'(c) && isTag) begin
          if (frameSynced[c]) begin
            frame_branch_pointer[c] <= 1'b1; // RQ9 RQ10 RQ11 RQ12
          end
          frameSynced[c] <= 1'b1; // RQ9 RQ10 RQ11 RQ12
        end
      end
    end
  end

  assign fifoIn = {rxQuad, rxCtx};

  // buffer in the data path
  irxdv_fifo #(.WIDTH(QW), .DEPTH(irxdv_pkg::FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset(reset),
    .inData(fifoIn),
    .inValid(fifoWr),
    .inReady(fifoInReady),
    .outData(fifoOut),
    .outValid(fifoOutValid),
    .outReady(!stageValid || outReady)
  );

  // output register stage
  always_ff @(posedge clk) begin
    if (reset) begin
      stageValid <= 1'b0;
      stage <= '0;
    end else if (!stageValid || outReady) begin
      stageValid <= fifoOutValid;
      stage <= fifoOut;
    end
  end

  assign outValid = stageValid;
  assign outQuad = stage[QW-1:2];
  assign outCtx = stage[1:0];
endmodule
`default_nettype wire

// [dv/irxdv_enh_properties.sv]
/* checker for the enhancement register and sync outputs.
   assumes it is bound onto irxdv_enh. */
`timescale 1ns/1ns
`default_nettype none
module irxdv_enh_properties (
  input wire logic clk, // clock
  input wire logic reset, // reset
  input wire irxdv_pkg::irxdv_bus_t bus, // host port
  input wire logic [31:0] rdData, // read data
  input wire logic [15:0] enhBits, // copy
  input wire logic [3:0] frame_branch_pointer, // pulse
  input wire logic [3:0] frameSynced // level
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // host write to each alias
  sequence setW; bus.wrEn && bus.addr == 12'hA80; endsequence
  sequence clrW; bus.wrEn && bus.addr == 12'hA84; endsequence
  a_set_alias: assert property (setW |-> ##2
    (~enhBits & $past(bus.wrData[15:0], 2) & 16'h3333) == 16'h0000) else $error("set lost");
  a_clear_alias: assert property (clrW |-> ##2
    (enhBits & $past(bus.wrData[15:0], 2) & 16'h3333) == 16'h0000) else $error("clear lost");
  a_zero_no_change: assert property ((!bus.wrEn || bus.wrData == 32'h0) |-> ##2 $stable(enhBits))
    else $error("bits moved");
  a_read_current: assert property (bus.rdEn && bus.addr == 12'hA80 |=> rdData == {16'h0000, enhBits})
    else $error("bad read");
  a_unmapped_zero: assert property (bus.rdEn && bus.addr[11:3] != 9'h150 |=> rdData == 32'h0)
    else $error("unmapped read");
  a_reserved_zero: assert property (rdData[31:16] == 16'h0 && (enhBits & 16'hCCCC) == 16'h0)
    else $error("reserved set");
  a_reset_clear: assert property ($fell(reset) |-> enhBits == 16'h0 && rdData == 32'h0)
    else $error("reset value");
  a_branch_pulse: assert property (frame_branch_pointer != 4'h0 |=> frame_branch_pointer == 4'h0)
    else $error("long branch");
  a_branch_in_sync: assert property ((frame_branch_pointer & ~frameSynced) == 4'h0)
    else $error("branch out of sync");
  a_sync_needs_strip: assert property (!enhBits[0] [*2] |-> !frameSynced[0])
    else $error("sync no strip");
endmodule
bind irxdv_enh irxdv_enh_properties i_irxdv_enh_properties (.clk(clk), .reset(reset), .bus(bus),
  .rdData(rdData), .enhBits(enhBits), .frame_branch_pointer(frame_branch_pointer), .frameSynced(frameSynced));
`default_nettype wire

// [dv/irxdv_host.sv]
/* host software model: one register access at a time.
   assumes the bench supplies the clock. */
`timescale 1ns/1ns
`default_nettype none
module irxdv_host (
  input wire logic clk, // clock
  output var irxdv_pkg::irxdv_bus_t bus, // host port
  input wire logic [31:0] rdData, // read data
  output logic [31:0] rdVal // last read
);
  initial bus = '0;
  // drive, hold one edge, release with inverted lines, sample
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{wrEn: w, rdEn: !w, addr: a, wrData: d};
    @(posedge clk);
    bus <= '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wrData: ~d};
    @(posedge clk);
    rdVal = rdData;
  endtask
endmodule
`default_nettype wire

// [dv/irxdv_enh_tb.sv]
/* self-checking bench for irxdv_enh.
   assumes the host model and the checker bind. */
`timescale 1ns/1ns
`default_nettype none
module irxdv_enh_tb;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} irxdv_row_t;
  logic clk = 0, reset = 1, rxValid = 0, outReady = 1, rxReady, outValid;
  logic [3:0] headerIncluded = 4'h0, frame_branch_pointer, frameSynced;
  logic [7:0] branchField = 8'h00;
  logic [1:0] rxCtx = 2'h0, outCtx;
  logic [31:0] rdData;
  logic [1:0] ctxSeen = 2'h0;
  logic [15:0] enhBits;
  irxdv_pkg::irxdv_bus_t bus;
  irxdv_pkg::irxdv_quad_t rxQuad = '0, outQuad;
  int err_count = 0, n_checks = 0, nBr = 0, nFull = 0;
  logic [31:0] got[$];
  irxdv_row_t rows[6];
  irxdv_enh i_irxdv_enh (.clk(clk), .reset(reset), .bus(bus), .rdData(rdData), .enhBits(enhBits),
    .headerIncluded(headerIncluded), .branchField(branchField), .rxQuad(rxQuad), .rxCtx(rxCtx),
    .rxValid(rxValid), .rxReady(rxReady), .outQuad(outQuad), .outCtx(outCtx), .outValid(outValid),
    .outReady(outReady), .frame_branch_pointer(frame_branch_pointer), .frameSynced(frameSynced));
  irxdv_host i_irxdv_host (.clk(clk), .bus(bus), .rdData(rdData), .rdVal());
  // clock
  initial forever #50 clk = ~clk;
  // stored quadlets, branch pulses, refusals
  always @(posedge clk) begin
    if (outValid === 1'b1 && outReady === 1'b1) begin
      got.push_back(outQuad.data);
      ctxSeen <= outCtx;
    end
    if (frame_branch_pointer[0] === 1'b1) nBr++;
    if (rxValid === 1'b1 && rxReady === 1'b0) nFull++;
  end
  task complete_run;
    if (err_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  // one packet, quadlet held until taken, then drained
  task automatic pkt(input logic [1:0] c, input int n, input logic tg);
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      rxQuad <= '{data: (tg && i == 2) ? 32'h1F37_0000 : 32'hA000_0000 + i, first: i == 0, last: i == n - 1};
      rxCtx <= c;
      rxValid <= 1'b1;
      do @(posedge clk); while (rxReady !== 1'b1);
    end
    rxValid <= 1'b0;
    repeat (4) @(posedge clk);
    for (int k = 0; k < 40 && outValid === 1'b1; k++) @(posedge clk);
  endtask
  // watchdog
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    complete_run;
  end
  initial begin
    rows = '{'{12'hA80, 32'hFFFF_FFFF, 32'h3333}, '{12'hA84, 32'h11, 32'h3322}, '{12'hA80, 32'h0, 32'h3322},
      '{12'hA88, 32'hFFFF_FFFF, 32'h3322}, '{12'hA84, 32'hFFFF_FFFF, 32'h0}, '{12'hA80, 32'h1111, 32'h1111}};
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    i_irxdv_host.acc(1'b0, 12'hA80, 32'h0);
    chk("reset value", 32'h0, i_irxdv_host.rdVal);
    foreach (rows[i]) begin
      i_irxdv_host.acc(1'b1, rows[i].a, rows[i].d);
      i_irxdv_host.acc(1'b0, 12'hA80, 32'h0);
      chk("enh reg", rows[i].e, i_irxdv_host.rdVal);
    end
    i_irxdv_host.acc(1'b0, 12'hA88, 32'h0);
    chk("unmapped", 32'h0, i_irxdv_host.rdVal);
    i_irxdv_host.acc(1'b0, 12'hA84, 32'h0);
    chk("clear alias read", 32'h1111, i_irxdv_host.rdVal);
    for (int c = 0; c < 4; c++) begin
      got.delete();
      pkt(c[1:0], 4, 1'b0);
      chk("strip", 32'hA000_0002, got.size() == 2 ? got[0] : 32'h0);
      chk("out ctx", c, ctxSeen);
    end
    headerIncluded <= 4'h8;
    got.delete();
    pkt(2'h3, 4, 1'b0);
    chk("kept", 32'h4, got.size());
    headerIncluded <= 4'h0;
    i_irxdv_host.acc(1'b1, 12'hA80, 32'h2);
    pkt(2'h0, 4, 1'b1);
    chk("sync off", 32'h0, frameSynced);
    branchField <= 8'h01;
    pkt(2'h0, 4, 1'b1);
    chk("synced", 32'h1, frameSynced[0]);
    pkt(2'h0, 4, 1'b1);
    chk("branch", 32'h1, nBr);
    i_irxdv_host.acc(1'b1, 12'hA84, 32'h1);
    i_irxdv_host.acc(1'b0, 12'hA80, 32'h0);
    chk("sync lost", 32'h0, frameSynced[0]);
    i_irxdv_host.acc(1'b1, 12'hA84, 32'hFFFF_FFFF);
    got.delete();
    outReady <= 1'b0;
    fork
      pkt(2'h2, 12, 1'b0);
      begin
        repeat (30) @(posedge clk);
        outReady <= 1'b1;
      end
    join
    chk("fill count", 32'hC, got.size());
    chk("refused", 32'h1, nFull > 0);
    // mid-run reset with every enhancement set
    i_irxdv_host.acc(1'b1, 12'hA80, 32'hFFFF_FFFF);
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    i_irxdv_host.acc(1'b0, 12'hA84, 32'h0);
    chk("reset clears", 32'h0, i_irxdv_host.rdVal);
    chk("sync after reset", 32'h0, frameSynced);
    complete_run;
  end
endmodule
`default_nettype wire
